// file: core/fault_recorder_regs.svh
// Register offsets, field positions and record layout constants of the fault recorder.
`ifndef FAULT_RECORDER_REGS_SVH
`define FAULT_RECORDER_REGS_SVH

// Register offsets on the management bus.
`define REG_TRANSITION_CAUSE 8'hEA
`define REG_PREVIOUS_STATE 8'hEB
`define REG_SNAPSHOT_ONE 8'hEC
`define REG_SNAPSHOT_TWO 8'hED
`define REG_SNAPSHOT_THREE 8'hEE
`define REG_SNAPSHOT_FOUR 8'hEF
`define REG_SNAPSHOT_FIVE 8'hF0
`define REG_NEXT_RECORD 8'hF1
`define REG_FAMILY_REVISION 8'hF5

// Answer given for an unmapped offset.
`define REG_UNMAPPED_VALUE 8'h00

// Field positions.
`define CAUSE_IN_USE_BIT 7
`define FAMILY_MSB 7
`define REVISION_MSB 3

// Record area: high address byte, first slot, slot step, full marker.
`define REC_AREA_HIGH 8'hF9
`define REC_FIRST_SLOT 8'h80
`define REC_LAST_SLOT 8'hF8
`define REC_SLOT_STEP 8'h08
`define REC_FULL 8'h00
`define REC_LAST_BYTE 3'h7
`define REC_FIRST_BYTE 3'h0

// Reset value of snapshot registers and of the tracked engine state.
`define SNAPSHOT_RESET 8'h00
`define ENGINE_STATE_RESET 6'h00

`endif

// file: core/fault_recorder_pkg.sv
// Types shared by the fault recorder modules.
package fault_recorder_pkg;

  // One record or register byte.
  typedef logic [7:0] byte_t;

  // Recorder control states: slot search after reset, idle, record write.
  typedef enum logic [1:0] {ST_SEARCH_READ, ST_SEARCH_CHECK, ST_IDLE, ST_WRITE} recorder_state_t;

endpackage

// file: core/record_memory.sv
// Byte memory holding the nonvolatile fault record area, with two registered read ports.
`timescale 1ns/1ns
module record_memory #(
  parameter int ADDR_WIDTH = 7
) (
  // Clock.
  input wire logic clock,
  // Write port.
  input wire logic writeEnable,
  input wire logic [ADDR_WIDTH-1:0] writeAddr,
  input wire fault_recorder_pkg::byte_t writeData,
  // Read port used by the free slot search.
  input wire logic [ADDR_WIDTH-1:0] readAddrA,
  output fault_recorder_pkg::byte_t readDataA,
  // Read port used by the host.
  input wire logic [ADDR_WIDTH-1:0] readAddrB,
  output fault_recorder_pkg::byte_t readDataB
);
  import fault_recorder_pkg::*;

  byte_t store [2**ADDR_WIDTH];

  // The array is not reset, so records survive a reset like nonvolatile cells; it starts erased.
  initial begin
    for (int i = 0; i < 2**ADDR_WIDTH; i++) begin
      store[i] = 8'h00;
    end
  end

  // Writes land one byte per cycle; both read ports return data one cycle after the address.
  always_ff @(posedge clock) begin
    if (writeEnable) begin
      store[writeAddr] <= writeData;
    end
    readDataA <= store[readAddrA];
    readDataB <= store[readAddrB];
  end

endmodule

// file: core/record_checksum.sv
// Checksum byte of a fault record, computed from its seven leading bytes.
`timescale 1ns/1ns
module record_checksum (
  // Leading record bytes in storage order.
  input wire fault_recorder_pkg::byte_t byteZero,
  input wire fault_recorder_pkg::byte_t byteOne,
  input wire fault_recorder_pkg::byte_t byteTwo,
  input wire fault_recorder_pkg::byte_t byteThree,
  input wire fault_recorder_pkg::byte_t byteFour,
  input wire fault_recorder_pkg::byte_t byteFive,
  input wire fault_recorder_pkg::byte_t byteSix,
  // Checksum so that all eight bytes sum to zero modulo 256.
  output fault_recorder_pkg::byte_t checksum
);
  import fault_recorder_pkg::*;

  byte_t partialSum;

  // A record cut short by power loss almost never sums to zero, so it shows as damaged.
  assign partialSum = byteZero + byteOne + byteTwo + byteThree + byteFour + byteFive + byteSix;
  assign checksum = 8'h00 - partialSum;

endmodule

// file: core/black_box_fault_recorder.sv
// Fault recorder: snapshot registers, record writer, free slot search and register read port.
// How it works
// - Every engine transition latches status flags, prior state and cause into snapshots.
// - If the entered state's trigger bit is set while idle with a slot left, seven snapshot bytes are written out.
// - An eighth checksum byte follows the seven record bytes.
// - Bytes ascend: cause, prior state, snapshots one to five, checksum, from 0xF980.
// - Cause bit 7 reads zero; stored in byte zero it marks the slot used.
// - The search takes the first slot whose in-use bit is clear as free.
// - Cause bits 5..0: host jump, ADC warning, supply fault, timeout, monitor, sequence.
// - Prior state register holds the previous state number in bits 5:0.
// - Snapshot one holds undervoltage flags of dual-use 3..1, high-voltage, supplies 4..1.
// - Snapshot two holds overvoltage of dual-use 1, high-voltage, supplies, dual-use 5,4 UV.
// - Snapshot three holds logic inputs 4..1 and overvoltage of dual-use 5..2.
// - Snapshot four holds ADC limits of dual-use 2,1, high-voltage, supplies, logic input 5.
// - Snapshot five holds extra ADC limits 2,1 and dual-use limits 5..3; top bits zero.
// - Next record pointer starts 0x80, steps by 8, reads 0x00 when full.
// - With one slot left the pointer reads the last slot value 0xF8.
// - Read-only identity register: family code in 7:4, hardware revision in 3:0.
`timescale 1ns/1ns
`include "fault_recorder_regs.svh"
module black_box_fault_recorder #(
  parameter int STATE_WIDTH = 6,
  parameter logic [3:0] FAMILY_CODE = 4'hA,  // Arbitrary value.
  parameter logic [3:0] HW_REVISION = 4'h3   // Arbitrary value.
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Sequence engine transition report.
  input wire logic transitionPulse,
  input wire logic [STATE_WIDTH-1:0] newState,
  input wire logic [5:0] causeFlags,
  input wire logic [2**STATE_WIDTH-1:0] recordWriteTrigger,
  // Monitored status: index 0..3 supplies 1..4, 4 high-voltage, 5..9 dual-use 1..5.
  input wire logic [9:0] undervoltageFlags,
  input wire logic [9:0] overvoltageFlags,
  input wire logic [9:0] adcLimitFlags,
  input wire logic [1:0] extraAdcLimitFlags,
  input wire logic [4:0] logicInputFlags,
  // Register read port.
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  output fault_recorder_pkg::byte_t regReadData,
  output logic regReadValid,
  // Record area read port, index 0 is address 0xF980.
  input wire logic [6:0] recordReadAddr,
  output fault_recorder_pkg::byte_t recordReadData,
  // Recorder activity.
  output logic recordBusy
);
  import fault_recorder_pkg::*;

  recorder_state_t state;
  logic [STATE_WIDTH-1:0] currentState;
  byte_t transitionCause;
  byte_t previousStateNumber;
  byte_t snapshotByteOne;
  byte_t snapshotByteTwo;
  byte_t snapshotByteThree;
  byte_t snapshotByteFour;
  byte_t snapshotByteFive;
  byte_t nextRecordPointer;
  byte_t next_cause;
  byte_t next_previous;
  byte_t next_one;
  byte_t next_two;
  byte_t next_three;
  byte_t next_four;
  byte_t next_five;
  byte_t markedCause;
  byte_t recordChecksum;
  byte_t slotAfter;
  byte_t searchData;
  byte_t memWriteData;
  byte_t recordBuf [8];
  byte_t readMux;
  logic [2:0] byteIdx;
  logic [6:0] memWriteAddr;
  logic memWrite;
  logic startRecord;

  // Snapshot values built from the live flags at the moment of a transition.
  assign next_cause = {2'h0, causeFlags};
  assign next_previous = {2'h0, currentState};
  assign next_one = undervoltageFlags[7:0];
  assign next_two = {overvoltageFlags[5:0], undervoltageFlags[9:8]};
  assign next_three = {logicInputFlags[3:0], overvoltageFlags[9:6]};
  assign next_four = {adcLimitFlags[6:0], logicInputFlags[4]};
  assign next_five = {3'h0, extraAdcLimitFlags, adcLimitFlags[9:7]};

  // The stored first byte carries the in-use mark that the register itself never shows.
  always_comb begin
    markedCause = next_cause;
    markedCause[`CAUSE_IN_USE_BIT] = 1'b1;
  end

  // Checksum over the seven record bytes as they will be stored.
  record_checksum u_checksum (
    .byteZero(markedCause),
    .byteOne(next_previous),
    .byteTwo(next_one),
    .byteThree(next_two),
    .byteFour(next_three),
    .byteFive(next_four),
    .byteSix(next_five),
    .checksum(recordChecksum)
  );

  // Tracks the engine state so the prior state is known at the next transition.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      currentState <= `ENGINE_STATE_RESET;
    end else if (transitionPulse) begin
      currentState <= newState;
    end
  end

  // Snapshot registers load on every transition and otherwise hold.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      transitionCause <= `SNAPSHOT_RESET;
      previousStateNumber <= `SNAPSHOT_RESET;
      snapshotByteOne <= `SNAPSHOT_RESET;
      snapshotByteTwo <= `SNAPSHOT_RESET;
      snapshotByteThree <= `SNAPSHOT_RESET;
      snapshotByteFour <= `SNAPSHOT_RESET;
      snapshotByteFive <= `SNAPSHOT_RESET;
    end else if (transitionPulse) begin
      transitionCause <= next_cause;
      previousStateNumber <= next_previous;
      snapshotByteOne <= next_one;
      snapshotByteTwo <= next_two;
      snapshotByteThree <= next_three;
      snapshotByteFour <= next_four;
      snapshotByteFive <= next_five;
    end
  end

  // A record starts only from idle, on a triggering state, while a slot is left.
  assign startRecord = (state == ST_IDLE) && transitionPulse && recordWriteTrigger[newState]
    && (nextRecordPointer != `REC_FULL);

  // Record buffer keeps the whole record steady even if snapshots change during the write.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        recordBuf[i] <= `SNAPSHOT_RESET;
      end
    end else if (startRecord) begin
      recordBuf[0] <= markedCause;
      recordBuf[1] <= next_previous;
      recordBuf[2] <= next_one;
      recordBuf[3] <= next_two;
      recordBuf[4] <= next_three;
      recordBuf[5] <= next_four;
      recordBuf[6] <= next_five;
      recordBuf[7] <= recordChecksum;
    end
  end

  // Pointer one slot on; the eight-bit wrap past the last slot yields the full value.
  assign slotAfter = nextRecordPointer + `REC_SLOT_STEP;

  // Recorder control: search for the first free slot after reset, then write records.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_SEARCH_READ;
      nextRecordPointer <= `REC_FIRST_SLOT;
      byteIdx <= `REC_FIRST_BYTE;
    end else begin
      unique case (state)
        ST_SEARCH_READ: begin
          state <= ST_SEARCH_CHECK;
        end
        ST_SEARCH_CHECK: begin
          if (!searchData[`CAUSE_IN_USE_BIT]) begin
            state <= ST_IDLE;
          end else begin
            nextRecordPointer <= slotAfter;
            state <= (slotAfter == `REC_FULL) ? ST_IDLE : ST_SEARCH_READ;
          end
        end
        ST_IDLE: begin
          if (startRecord) begin
            state <= ST_WRITE;
            byteIdx <= `REC_FIRST_BYTE;
          end
        end
        ST_WRITE: begin
          byteIdx <= byteIdx + 3'h1;
          if (byteIdx == `REC_LAST_BYTE) begin
            nextRecordPointer <= slotAfter;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Bytes go out one per cycle at ascending addresses inside the current slot.
  assign memWrite = (state == ST_WRITE);
  assign memWriteAddr = {nextRecordPointer[6:3], byteIdx};
  assign memWriteData = recordBuf[byteIdx];
  assign recordBusy = (state != ST_IDLE);

  // Record area storage.
  record_memory #(
    .ADDR_WIDTH(7)
  ) u_memory (
    .clock(clock),
    .writeEnable(memWrite),
    .writeAddr(memWriteAddr),
    .writeData(memWriteData),
    .readAddrA(nextRecordPointer[6:0]),
    .readDataA(searchData),
    .readAddrB(recordReadAddr),
    .readDataB(recordReadData)
  );

  // Register decode; every register here is read-only and unmapped offsets read zero.
  always_comb begin
    unique case (regAddr)
      `REG_TRANSITION_CAUSE: readMux = transitionCause;
      `REG_PREVIOUS_STATE: readMux = previousStateNumber;
      `REG_SNAPSHOT_ONE: readMux = snapshotByteOne;
      `REG_SNAPSHOT_TWO: readMux = snapshotByteTwo;
      `REG_SNAPSHOT_THREE: readMux = snapshotByteThree;
      `REG_SNAPSHOT_FOUR: readMux = snapshotByteFour;
      `REG_SNAPSHOT_FIVE: readMux = snapshotByteFive;
      `REG_NEXT_RECORD: readMux = nextRecordPointer;
      `REG_FAMILY_REVISION: readMux = {FAMILY_CODE, HW_REVISION};
      default: readMux = `REG_UNMAPPED_VALUE;
    endcase
  end

  // Read data is registered and answers one cycle after the read strobe.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regReadData <= `REG_UNMAPPED_VALUE;
      regReadValid <= 1'b0;
    end else begin
      regReadValid <= regRead;
      if (regRead) begin
        regReadData <= readMux;
      end
    end
  end

  // Running sum of the bytes written in the current record, read only by the checks below.
  byte_t sumAcc;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sumAcc <= 8'h00;
    end else if (memWrite) begin
      sumAcc <= (byteIdx == `REC_LAST_BYTE) ? 8'h00 : sumAcc + memWriteData;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // A record write occupies exactly eight busy cycles and then returns to idle.
  sequence seq_record_write;
    (memWrite && byteIdx == 3'h0) [*1] ##1 (memWrite && byteIdx == 3'h1)
      ##6 memWrite ##1 !memWrite;
  endsequence

  // Snapshot registers follow the flags seen at the transition, bit for bit.
  a_cause_capture: assert property (transitionPulse |=>
    transitionCause == {2'h0, $past(causeFlags)})
    else $error("cause register does not match the transition cause");
  a_prior_state: assert property (transitionPulse |=>
    previousStateNumber[5:0] == $past(currentState))
    else $error("prior state register does not hold the previous state");
  a_byte_one_map: assert property (transitionPulse |=>
    snapshotByteOne == $past(undervoltageFlags[7:0]))
    else $error("snapshot one does not hold the undervoltage flags");
  a_byte_two_map: assert property (transitionPulse |=>
    snapshotByteTwo[1:0] == $past(undervoltageFlags[9:8]))
    else $error("snapshot two low bits do not hold dual-use 5 and 4 undervoltage");
  a_byte_two_top: assert property (transitionPulse |=>
    snapshotByteTwo[7:2] == $past(overvoltageFlags[5:0]))
    else $error("snapshot two high bits do not hold the overvoltage flags");
  a_byte_three_map: assert property (transitionPulse |=>
    snapshotByteThree == {$past(logicInputFlags[3:0]), $past(overvoltageFlags[9:6])})
    else $error("snapshot three does not hold logic inputs and overvoltage flags");
  a_byte_four_map: assert property (transitionPulse |=>
    snapshotByteFour == {$past(adcLimitFlags[6:0]), $past(logicInputFlags[4])})
    else $error("snapshot four does not hold limit flags and logic input five");
  a_byte_five_map: assert property (transitionPulse |=>
    snapshotByteFive[4:0] == {$past(extraAdcLimitFlags), $past(adcLimitFlags[9:7])})
    else $error("snapshot five does not hold the extra and dual-use limit flags");

  // Reserved bits stay zero and snapshots three and four hold between transitions.
  a_byte_five_top: assert property (
    snapshotByteFive[7:5] == 3'h0 && transitionCause[7:6] == 2'h0)
    else $error("unused snapshot or cause bits are not zero");
  a_snapshot_hold: assert property (!transitionPulse |=>
    $stable(snapshotByteThree) && $stable(snapshotByteFour))
    else $error("snapshot changed without a transition");

  // Record writing: eight bytes, in-use mark first, ascending, balanced by the checksum.
  a_write_start: assert property (startRecord |=>
    seq_record_write)
    else $error("record write did not run eight bytes");
  a_in_use_mark: assert property (memWrite && byteIdx == 3'h0 |->
    memWriteData[7] && memWriteAddr[2:0] == 3'h0)
    else $error("first record byte lacks the in-use mark");
  a_ascending_addr: assert property (memWrite && byteIdx != 3'h7 |=>
    memWriteAddr == $past(memWriteAddr) + 7'h01)
    else $error("record bytes are not at ascending addresses");
  a_checksum_zero: assert property (memWrite && byteIdx == 3'h7 |->
    8'(sumAcc + memWriteData) == 8'h00)
    else $error("checksum does not balance the record");

  // Pointer: one slot per record, inside the area, last slot shown, no record when full.
  a_pointer_step: assert property (memWrite && byteIdx == 3'h7 |=>
    nextRecordPointer == 8'($past(nextRecordPointer) + 8'h08))
    else $error("pointer did not advance by one slot");
  a_pointer_range: assert property (
    nextRecordPointer[2:0] == 3'h0 && (nextRecordPointer[7] || nextRecordPointer == 8'h00))
    else $error("pointer left the record area");
  a_last_slot: assert property (
    memWrite && byteIdx == 3'h7 && nextRecordPointer == 8'hF0
    |=> nextRecordPointer == `REC_LAST_SLOT)
    else $error("pointer does not show the last slot with one slot left");
  a_full_refuse: assert property (
    state == ST_IDLE && transitionPulse && nextRecordPointer == `REC_FULL |=> !recordBusy)
    else $error("a record was started with the record area full");

  // Search stops at the first slot whose in-use bit is clear.
  a_search_free: assert property (state == ST_SEARCH_CHECK && !searchData[7] |=>
    state == ST_IDLE && $stable(nextRecordPointer))
    else $error("search passed over a free slot");

  // Register reads answer one cycle later: identity with its value, cause without the in-use bit.
  a_identity_read: assert property (regRead && regAddr == `REG_FAMILY_REVISION |=>
    regReadValid && regReadData == {FAMILY_CODE, HW_REVISION})
    else $error("identity register read wrong");
  a_cause_read: assert property (regRead && regAddr == `REG_TRANSITION_CAUSE |=>
    regReadValid && !regReadData[7])
    else $error("cause register read shows the in-use bit");

endmodule

// file: dv/host_model.sv
// Host model that reads the recorder registers and the record area.
`timescale 1ns/1ns
module host_model (
  // Clock.
  input wire logic clock,
  // Register read port.
  output logic [7:0] regAddr,
  output logic regRead,
  input wire fault_recorder_pkg::byte_t regReadData,
  input wire logic regReadValid,
  // Record area read port.
  output logic [6:0] recordReadAddr,
  input wire fault_recorder_pkg::byte_t recordReadData
);
  import fault_recorder_pkg::*;

  // Idle request lines at time zero.
  initial begin
    regRead = 1'b0;
    regAddr = 8'h00;
    recordReadAddr = 7'h00;
  end

  // One register read: request stands for one edge, the answer comes a cycle later.
  task automatic read_reg(input logic [7:0] addr, output byte_t data, output logic valid);
    @(posedge clock);
    #1;
    regRead = 1'b1;
    regAddr = addr;
    @(posedge clock);
    #1;
    regRead = 1'b0;
    regAddr = ~addr; // A released address keeps no stale value.
    valid = regReadValid;
    data = regReadData;
  endtask

  // The identity register tells the two family members apart.
  task automatic read_identity(output byte_t data, output logic valid);
    read_reg(8'hF5, data, valid);
  endtask

  // One record byte, data is registered one cycle after the index.
  task automatic read_rec(input logic [6:0] idx, output byte_t data);
    @(posedge clock);
    #1;
    recordReadAddr = idx;
    @(posedge clock);
    #1;
    data = recordReadData;
  endtask
endmodule

// file: dv/black_box_fault_recorder_tb.sv
// Self-checking testbench of the fault recorder.
`timescale 1ns/1ns
`include "fault_recorder_regs.svh"
module black_box_fault_recorder_tb;
  import fault_recorder_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic transitionPulse = 1'b0;
  logic [5:0] newState = 6'h00;
  logic [5:0] causeFlags = 6'h00;
  logic [63:0] recordWriteTrigger = 64'h0;
  logic [9:0] undervoltageFlags = 10'h000;
  logic [9:0] overvoltageFlags = 10'h000;
  logic [9:0] adcLimitFlags = 10'h000;
  logic [1:0] extraAdcLimitFlags = 2'h0;
  logic [4:0] logicInputFlags = 5'h00;
  logic [7:0] regAddr;
  logic regRead;
  byte_t regReadData;
  logic regReadValid;
  logic [6:0] recordReadAddr;
  byte_t recordReadData;
  logic recordBusy;
  int miscompares = 0;
  int testsRun = 0;
  byte_t exp [0:7];
  logic [5:0] lastState = 6'h00;
  logic [7:0] ptr = 8'h80;

  // Free-running 20 MHz clock.
  always #25 clock = ~clock;

  black_box_fault_recorder dut (.clock, .rst_n, .transitionPulse, .newState, .causeFlags,
    .recordWriteTrigger, .undervoltageFlags, .overvoltageFlags, .adcLimitFlags,
    .extraAdcLimitFlags, .logicInputFlags, .regAddr, .regRead, .regReadData, .regReadValid,
    .recordReadAddr, .recordReadData, .recordBusy);

  host_model host (.clock, .regAddr, .regRead, .regReadData, .regReadValid, .recordReadAddr,
    .recordReadData);

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compares one value with its expectation.
  task automatic check(input byte_t seen, input byte_t expected);
    testsRun++;
    if (seen !== expected) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  // Reads one register and compares the answer.
  task automatic rd(input logic [7:0] addr, input byte_t expected);
    byte_t d;
    logic v;
    host.read_reg(addr, d, v);
    check({7'h00, v}, 8'h01);
    check(d, expected);
  endtask

  // Waits, under a bound, until the recorder is idle; n counts the busy edges.
  task automatic wait_idle(output int n);
    n = 0;
    while (recordBusy !== 1'b0) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 40) begin
        miscompares++;
        complete_run();
      end
    end
  endtask

  // Drives all status flags from one pattern.
  task automatic set_flags(input logic [9:0] p);
    undervoltageFlags = p;
    overvoltageFlags = ~p;
    adcLimitFlags = {p[4:0], p[9:5]};
    extraAdcLimitFlags = p[1:0];
    logicInputFlags = p[6:2];
  endtask

  // One engine transition; works out the snapshot bytes it must capture.
  task automatic transition(input logic [5:0] state, input logic [5:0] cause, input logic trig);
    @(posedge clock);
    #1;
    transitionPulse = 1'b1;
    newState = state;
    causeFlags = cause;
    recordWriteTrigger = 64'(trig) << state;
    exp[0] = {2'h0, cause};
    exp[1] = {2'h0, lastState};
    exp[2] = undervoltageFlags[7:0];
    exp[3] = {overvoltageFlags[5:0], undervoltageFlags[9:8]};
    exp[4] = {logicInputFlags[3:0], overvoltageFlags[9:6]};
    exp[5] = {adcLimitFlags[6:0], logicInputFlags[4]};
    exp[6] = {3'h0, extraAdcLimitFlags, adcLimitFlags[9:7]};
    exp[7] = 8'h00 - (exp[0] | 8'h80) - exp[1] - exp[2] - exp[3] - exp[4] - exp[5] - exp[6];
    lastState = state;
    @(posedge clock);
    #1;
    transitionPulse = 1'b0;
    newState = ~state;
    causeFlags = ~cause;
  endtask

  // Reads the seven snapshot registers.
  task automatic check_snap();
    for (int i = 0; i < 7; i++) begin
      rd(`REG_TRANSITION_CAUSE + 8'(i), exp[i]);
    end
  endtask

  // A triggered transition: busy for eight cycles, eight bytes stored, pointer steps.
  task automatic write_record(input logic [5:0] state);
    int n;
    byte_t d;
    set_flags({state, state[3:0]} ^ 10'h2A5);
    transition(state, 6'h01 << (state % 6), 1'b1);
    check({7'h00, recordBusy}, 8'h01);
    wait_idle(n);
    check(8'(n), 8'h08);
    for (int i = 0; i < 8; i++) begin
      host.read_rec(ptr[6:0] + 7'(i), d);
      check(d, i == 0 ? (exp[0] | 8'h80) : exp[i]);
    end
    ptr = ptr + `REC_SLOT_STEP;
    rd(`REG_NEXT_RECORD, ptr);
  endtask

  // Values after reset, identity and an unmapped offset.
  task automatic s_reset_values();
    int n;
    byte_t d;
    logic v;
    wait_idle(n);
    rd(`REG_NEXT_RECORD, 8'h80);
    host.read_identity(d, v);
    check({7'h00, v}, 8'h01);
    check(d, 8'hA3);
    for (int i = 0; i < 7; i++) begin
      rd(`REG_TRANSITION_CAUSE + 8'(i), 8'h00);
    end
    rd(8'hF2, 8'h00);
  endtask

  // Every cause code once; flags change after capture and the snapshots must hold.
  task automatic s_capture();
    for (int k = 0; k < 6; k++) begin
      set_flags(k[0] ? 10'h35A : 10'h0A5);
      transition(6'(k * 9 + 1), 6'h01 << k, 1'b0);
      check({7'h00, recordBusy}, 8'h00);
      set_flags(10'h3FF);
      check_snap();
    end
  endtask

  // A trigger that arrives while a record is written is dropped.
  task automatic s_busy_drop();
    int n;
    transition(6'h10, 6'h04, 1'b1);
    transition(6'h11, 6'h02, 1'b1);
    wait_idle(n);
    ptr = ptr + `REC_SLOT_STEP;
    rd(`REG_NEXT_RECORD, ptr);
    check_snap();
  endtask

  // Reset in mid-run; the search finds the next free slot again.
  task automatic s_research();
    int n;
    @(posedge clock);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    lastState = 6'h00;
    check({7'h00, recordBusy}, 8'h01);
    wait_idle(n);
    rd(`REG_NEXT_RECORD, ptr);
  endtask

  // Fills the area; a full area takes no more records.
  task automatic s_fill();
    for (int k = 0; k < 16 && ptr != `REC_FULL; k++) begin
      write_record(6'(k + 32));
    end
    check(ptr, `REC_FULL);
    transition(6'h05, 6'h01, 1'b1);
    check({7'h00, recordBusy}, 8'h00);
    rd(`REG_NEXT_RECORD, `REC_FULL);
    s_research();
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(posedge clock);
    #1;
    rst_n = 1'b1;
    s_reset_values();
    s_capture();
    write_record(6'h3F);
    s_busy_drop();
    s_research();
    s_fill();
    complete_run();
  end
endmodule
